// >>> rtl/ccl_top.sv
// Comparator control and status logic with APB register access
// Register map, byte addresses on the APB side
// 0x030 control/status: power, bandgap, result, flag, enable, capture, mode
// 0x034 converter control B: multiplexer enable in bit 6
// 0x038 converter channel select in bits 2:0
// 0x03C interrupt status, bit 0 aliases the flag, write one to clear
// 0x040 interrupt mask, bit 0 gates the request
`timescale 1ns/1ps
`default_nettype none
`include "ccl_map.svh"
module ccl_top
   import ccl_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Analogue comparator core
   input  wire logic        cmp_raw,
   output logic             cmp_power_off,
   output logic             cmp_bandgap_select,
   output logic             neg_use_mux,
   output logic      [2:0]  neg_channel,
   // Converter state
   input  wire logic        converter_enable,
   input  wire logic        converter_power_reduce,
   // Processor interrupt handshake
   input  wire logic        irq_global_enable,
   input  wire logic        irq_ack,
   output logic             irq,
   // Timer input-capture front end
   output logic             capture_out
);

   // Bus slave state and prepared answer
   ccl_apb_e    state_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic [31:0] rdata_d;

   // Writable fields of the control/status register
   logic        pwr_off_q;
   logic        bandgap_q;
   logic        flag_q;
   logic        ien_q;
   logic        capt_q;
   logic [1:0]  mode_q;

   // Converter-side selection kept here
   logic        mux_en_q;
   logic [2:0]  chan_q;

   // Interrupt gating
   logic        imask_q;
   logic        irq_q;

   // Registered copies driven towards the core and the timer
   logic        neg_mux_q;
   logic [2:0]  neg_chan_q;
   logic        capt_out_q;

   // Address decode, used at the setup edge, and write strobes, valid only at the commit edge
   logic        hit;
   logic        commit;
   logic        wr_csr;
   logic        wr_ccb;
   logic        wr_mux;
   logic        wr_ist;
   logic        wr_imsk;

   // Other combinational helpers
   logic        flag_clr;
   logic        mux_sub;
   logic [7:0]  csr_rd;

   // Synchroniser and event detector share one carrier
   ccl_evt_if evt_if ();

   // Result bit, event detector and capture route all read the
   // same synchronised copy, so software never sees them disagree
   // Raw level is asynchronous to pclk, so two stages first
   ccl_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .async_in(cmp_raw),
      .sig     (evt_if)
   );

   // Detector compares each sample with the one before it
   ccl_edge u_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .sig     (evt_if)
   );

   // A new mode takes effect at the commit edge; an edge already in
   // the detector is then judged by it, hence the stray-request hazard
   // Mode field steers the detector
   assign evt_if.mode = mode_q;

   // Only whole aligned words are mapped; any other address errors
   // Address decode
   always_comb begin
      hit = 1'b0;
      unique case (paddr)
         `CCL_ADDR_CSR:  hit = 1'b1;
         `CCL_ADDR_CCB:  hit = 1'b1;
         `CCL_ADDR_MUX:  hit = 1'b1;
         `CCL_ADDR_IST:  hit = 1'b1;
         `CCL_ADDR_IMSK: hit = 1'b1;
         default:        hit = 1'b0;
      endcase
   end

   // Bit 5 shows the synchronised level; there is no storage behind it
   // Control/status byte as software sees it
   always_comb begin
      csr_rd                   = 8'h00;
      csr_rd[`CCL_CSR_PWR_OFF] = pwr_off_q;
      csr_rd[`CCL_CSR_BANDGAP] = bandgap_q;
      csr_rd[`CCL_CSR_RESULT]  = evt_if.level;
      csr_rd[`CCL_CSR_FLAG]    = flag_q;
      csr_rd[`CCL_CSR_IEN]     = ien_q;
      csr_rd[`CCL_CSR_CAPT]    = capt_q;
      csr_rd[`CCL_CSR_MODE_HI] = mode_q[1];
      csr_rd[`CCL_CSR_MODE_LO] = mode_q[0];
   end

   // Unmapped reads return zero so that no stale data leaks out
   // Read data mux; narrow registers sit in the low bits
   always_comb begin
      rdata_d = `CCL_DATA_ZERO;
      unique case (paddr)
         `CCL_ADDR_CSR: begin
            rdata_d[7:0] = csr_rd;
         end
         `CCL_ADDR_CCB: begin
            rdata_d[`CCL_CCB_MUX_EN] = mux_en_q;
         end
         `CCL_ADDR_MUX: begin
            rdata_d[`CCL_MUX_CH_HI:`CCL_MUX_CH_LO] = chan_q;
         end
         `CCL_ADDR_IST: begin
            rdata_d[`CCL_IST_CMP] = flag_q;
         end
         `CCL_ADDR_IMSK: begin
            rdata_d[`CCL_IST_CMP] = imask_q;
         end
         default: begin
            rdata_d = `CCL_DATA_ZERO;
         end
      endcase
   end

   // Writes land only here, never in the setup cycle, so an abandoned
   // transfer leaves every register untouched
   // Access completes on the edge where pready is seen high
   assign commit  = (state_q == APB_ACCESS) & psel & penable & pready_q;
   assign wr_csr  = commit & pwrite & (paddr == `CCL_ADDR_CSR);
   assign wr_ccb  = commit & pwrite & (paddr == `CCL_ADDR_CCB);
   assign wr_mux  = commit & pwrite & (paddr == `CCL_ADDR_MUX);
   assign wr_ist  = commit & pwrite & (paddr == `CCL_ADDR_IST);
   assign wr_imsk = commit & pwrite & (paddr == `CCL_ADDR_IMSK);

   // Bus phase tracking; answer is prepared in the setup cycle
   // so that the access phase never waits; pslverr is decided from the
   // address alone, and an unmapped write is dropped as no strobe fires
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= APB_IDLE;
         pready_q  <= `CCL_BIT_RST;
         pslverr_q <= `CCL_BIT_RST;
         prdata_q  <= `CCL_DATA_ZERO;
      end else begin
         unique case (state_q)
            APB_IDLE: begin
               if (psel && !penable) begin
                  state_q   <= APB_ACCESS;
                  pready_q  <= 1'b1;
                  pslverr_q <= ~hit;
                  prdata_q  <= pwrite ? `CCL_DATA_ZERO : rdata_d;
               end
            end
            APB_ACCESS: begin
               if (commit || !psel) begin
                  state_q   <= APB_IDLE;
                  pready_q  <= 1'b0;
                  pslverr_q <= 1'b0;
                  prdata_q  <= `CCL_DATA_ZERO;
               end
            end
         endcase
      end
   end

   // Writable control bits of the control/status register;
   // the result bit has no storage, so writes to it vanish.
   // Mode and power bits change without any guard; flipping them while
   // the enable is set can raise a stray request, so software clears
   // the enable first
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwr_off_q <= `CCL_BIT_RST;
         bandgap_q <= `CCL_BIT_RST;
         ien_q     <= `CCL_BIT_RST;
         capt_q    <= `CCL_BIT_RST;
         mode_q    <= `CCL_MODE_RST;
      end else if (wr_csr) begin
         pwr_off_q <= pwdata[`CCL_CSR_PWR_OFF];
         bandgap_q <= pwdata[`CCL_CSR_BANDGAP];
         ien_q     <= pwdata[`CCL_CSR_IEN];
         capt_q    <= pwdata[`CCL_CSR_CAPT];
         mode_q    <= pwdata[`CCL_CSR_MODE_HI:`CCL_CSR_MODE_LO];
      end
   end

   // Kept here because the converter register bank lies outside this block
   // Multiplexer enable bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mux_en_q <= `CCL_BIT_RST;
      end else if (wr_ccb) begin
         mux_en_q <= pwdata[`CCL_CCB_MUX_EN];
      end
   end

   // Only the low three bits are stored; upper bits read back zero
   // Converter channel field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         chan_q <= `CCL_CH_RST;
      end else if (wr_mux) begin
         chan_q <= pwdata[`CCL_MUX_CH_HI:`CCL_MUX_CH_LO];
      end
   end

   // Interrupt mask, an extra gate beside the enable bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         imask_q <= `CCL_BIT_RST;
      end else if (wr_imsk) begin
         imask_q <= pwdata[`CCL_IST_CMP];
      end
   end

   // irq_ack is a one-cycle pulse from the processor's vector fetch
   // Flag clears: vector taken, or one written at either alias
   assign flag_clr = irq_ack
                   | (wr_csr & pwdata[`CCL_CSR_FLAG])
                   | (wr_ist & pwdata[`CCL_IST_CMP]);

   // Sticky flag; a new event beats a clear in the same cycle,
   // so an edge that arrives while the handler clears the flag is kept
   // rather than lost between two reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= `CCL_BIT_RST;
      end else if (evt_if.evt) begin
         flag_q <= 1'b1;
      end else if (flag_clr) begin
         flag_q <= 1'b0;
      end
   end

   // Interrupt request level; dropping the enable drops it next edge.
   // The mask is a second gate; it resets closed, so software opens it
   // once at start-up and then works with the enable bit alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= `CCL_BIT_RST;
      end else begin
         irq_q <= flag_q & ien_q & irq_global_enable & imask_q;
      end
   end

   // Both converter inputs are same-clock levels, so no synchroniser
   // Substitution needs mux enable, converter off, converter powered
   assign mux_sub = mux_en_q & ~converter_enable
                  & ~converter_power_reduce;

   // Channel output is held at zero while the pin is in use, so the
   // core never sees a stale channel when substitution begins
   // Negative input selection towards the analogue core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         neg_mux_q  <= `CCL_BIT_RST;
         neg_chan_q <= `CCL_CH_RST;
      end else begin
         neg_mux_q  <= mux_sub;
         neg_chan_q <= mux_sub ? chan_q : `CCL_CH_RST;
      end
   end

   // Gated level, not an edge, so no capture is lost to a short pulse
   // Capture route; the timer does its own filtering and edge pick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capt_out_q <= `CCL_BIT_RST;
      end else begin
         capt_out_q <= capt_q & evt_if.level;
      end
   end

   // Outputs, each from a flip-flop
   assign prdata             = prdata_q;
   assign pready             = pready_q;
   assign pslverr            = pslverr_q;
   assign cmp_power_off      = pwr_off_q;
   assign cmp_bandgap_select = bandgap_q;
   assign neg_use_mux        = neg_mux_q;
   assign neg_channel        = neg_chan_q;
   assign irq                = irq_q;
   assign capture_out        = capt_out_q;

endmodule
`default_nettype wire

// >>> pkg/ccl_map.svh
// Register offsets, field positions and reset values of the comparator control logic
`ifndef CCL_MAP_SVH
`define CCL_MAP_SVH
// Byte addresses on the register bus
`define CCL_ADDR_CSR     12'h030
`define CCL_ADDR_CCB     12'h034
`define CCL_ADDR_MUX     12'h038
`define CCL_ADDR_IST     12'h03C
`define CCL_ADDR_IMSK    12'h040
// Control/status register fields
`define CCL_CSR_PWR_OFF  7
`define CCL_CSR_BANDGAP  6
`define CCL_CSR_RESULT   5
`define CCL_CSR_FLAG     4
`define CCL_CSR_IEN      3
`define CCL_CSR_CAPT     2
`define CCL_CSR_MODE_HI  1
`define CCL_CSR_MODE_LO  0
// Converter control B field
`define CCL_CCB_MUX_EN   6
// Converter mux register channel field
`define CCL_MUX_CH_HI    2
`define CCL_MUX_CH_LO    0
// Interrupt status and mask field
`define CCL_IST_CMP      0
// Reset values
`define CCL_BIT_RST      1'b0
`define CCL_MODE_RST     2'h0
`define CCL_CH_RST       3'h0
`define CCL_DATA_ZERO    32'h0000_0000
`endif

// >>> pkg/ccl_pkg.sv
// Types shared by the comparator control logic
`default_nettype none
package ccl_pkg;
   // Interrupt mode field decode, in code order 00..11
   typedef enum logic [1:0] {
      MODE_TOGGLE,
      MODE_RSVD,
      MODE_FALL,
      MODE_RISE
   } ccl_mode_e;
   // Register bus slave phase
   typedef enum logic {
      APB_IDLE,
      APB_ACCESS
   } ccl_apb_e;
endpackage
`default_nettype wire

// >>> pkg/ccl_evt_if.sv
// Carrier between synchroniser, event detector and the control logic
`timescale 1ns/1ps
`default_nettype none
interface ccl_evt_if;
   logic       level;
   logic [1:0] mode;
   logic       evt;
   modport sync (output level);
   modport det  (input level, input mode, output evt);
   modport ctl  (input level, input evt, output mode);
endinterface
`default_nettype wire

// >>> rtl/ccl_sync.sv
// Two-stage synchroniser for the raw comparator output
`timescale 1ns/1ps
`default_nettype none
`include "ccl_map.svh"
module ccl_sync
   import ccl_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Asynchronous comparator level
   input  wire logic async_in,
   // Synchronised level
   ccl_evt_if.sync   sig
);
   logic meta_q;
   logic sync_q;

   // First stage is read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= `CCL_BIT_RST;
         sync_q <= `CCL_BIT_RST;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sig.level = sync_q;
endmodule
`default_nettype wire

// >>> rtl/ccl_edge.sv
// Edge detector and interrupt mode decoder on the synchronised level
`timescale 1ns/1ps
`default_nettype none
`include "ccl_map.svh"
module ccl_edge
   import ccl_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Level in, event out
   ccl_evt_if.det    sig
);
   logic prev_q;
   logic evt_q;
   logic evt_d;

   // Previous sample for comparison
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_q <= `CCL_BIT_RST;
      end else begin
         prev_q <= sig.level;
      end
   end

   // Match the sample pair against the selected mode
   always_comb begin
      evt_d = 1'b0;
      unique case (ccl_mode_e'(sig.mode))
         MODE_TOGGLE: evt_d = sig.level ^ prev_q;
         MODE_RSVD:   evt_d = 1'b0;
         MODE_FALL:   evt_d = prev_q & ~sig.level;
         MODE_RISE:   evt_d = ~prev_q & sig.level;
      endcase
   end

   // Registered one-cycle event pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         evt_q <= `CCL_BIT_RST;
      end else begin
         evt_q <= evt_d;
      end
   end

   assign sig.evt = evt_q;
endmodule
`default_nettype wire

// >>> sim/ccl_top_props.sv
// Concurrent checks on the ports of the comparator control logic
`timescale 1ns/1ps
`default_nettype none
`include "ccl_map.svh"
module ccl_top_props (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Register bus
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Comparator and converter side
   input wire logic        cmp_raw,
   input wire logic        cmp_power_off,
   input wire logic        cmp_bandgap_select,
   input wire logic        neg_use_mux,
   input wire logic [2:0]  neg_channel,
   input wire logic        converter_enable,
   input wire logic        converter_power_reduce,
   // Interrupt and capture
   input wire logic        irq_global_enable,
   input wire logic        irq_ack,
   input wire logic        irq,
   input wire logic        capture_out
);
   // Upper control bits of a write, named so that $past sees a plain signal
   logic [1:0] wr_hi;
   logic       csr_wr;
   assign wr_hi  = pwdata[7:6];
   assign csr_wr = psel && penable && pready && pwrite && paddr == `CCL_ADDR_CSR;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single cycle after setup");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data not zero outside access");
   a_ctrl_bits_out: assert property (csr_wr |=> {cmp_power_off, cmp_bandgap_select} == $past(wr_hi))
      else $error("power or bandgap output differs from written bits");
   a_mux_needs_off: assert property (neg_use_mux |-> !$past(converter_enable) && !$past(converter_power_reduce))
      else $error("mux substitution while converter on or power reduced");
   a_chan_idle_zero: assert property (!neg_use_mux |-> neg_channel == 3'h0)
      else $error("channel nonzero without substitution");
   a_irq_needs_gie: assert property (irq |-> $past(irq_global_enable))
      else $error("irq without global enable");
   a_ack_drops_irq: assert property (irq_ack |-> ##2 !irq)
      else $error("irq still high after vector acknowledge");
   a_capture_tracks: assert property (capture_out |-> $past(cmp_raw, 3))
      else $error("capture output not backed by comparator level");
endmodule
bind ccl_top ccl_top_props ccl_top_props_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .cmp_raw(cmp_raw), .cmp_power_off(cmp_power_off), .cmp_bandgap_select(cmp_bandgap_select),
   .neg_use_mux(neg_use_mux), .neg_channel(neg_channel), .converter_enable(converter_enable),
   .converter_power_reduce(converter_power_reduce), .irq_global_enable(irq_global_enable),
   .irq_ack(irq_ack), .irq(irq), .capture_out(capture_out));
`default_nettype wire

// >>> sim/ccl_cmp_model.sv
// Behavioural analogue comparator core with input selection
`timescale 1ns/1ps
`default_nettype none
module ccl_cmp_model (
   // Controls from the logic
   input wire logic       power_off,
   input wire logic       bandgap_select,
   input wire logic       neg_use_mux,
   input wire logic [2:0] neg_channel,
   // Voltages in millivolts
   input var  int         pos_mv,
   input var  int         bg_mv,
   input var  int         neg_mv,
   input var  int         ch_mv [8],
   // Raw comparison
   output logic           cmp_raw
);
   // Unpowered core drives low, so a stale high never survives power off
   always_comb begin
      if (power_off)
         cmp_raw = 1'b0;
      else
         cmp_raw = (bandgap_select ? bg_mv : pos_mv) > (neg_use_mux ? ch_mv[neg_channel] : neg_mv);
   end
endmodule
`default_nettype wire

// >>> sim/ccl_top_tb_top.sv
// Self-checking bench for the comparator control logic
`timescale 1ns/1ps
`default_nettype none
`include "ccl_map.svh"
module ccl_top_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, cmp_raw, conv_en, conv_pr, gie, irq_ack;
   logic        pready, pslverr, pwr_off, bg_sel, use_mux, irq, capture_out, erq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [2:0]  chan;
   int          pos_mv, bg_mv, neg_mv, err_count, n_checks;
   int          ch_mv [8];

   ccl_top ccl_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
      .cmp_power_off(pwr_off), .cmp_bandgap_select(bg_sel), .neg_use_mux(use_mux), .neg_channel(chan),
      .converter_enable(conv_en), .converter_power_reduce(conv_pr), .irq_global_enable(gie),
      .irq_ack(irq_ack), .irq(irq), .capture_out(capture_out));
   ccl_cmp_model ccl_cmp_model_i (.power_off(pwr_off), .bandgap_select(bg_sel), .neg_use_mux(use_mux),
      .neg_channel(chan), .pos_mv(pos_mv), .bg_mv(bg_mv), .neg_mv(neg_mv), .ch_mv(ch_mv), .cmp_raw(cmp_raw));

   // 20 MHz clock
   always #25 pclk = ~pclk;

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; the idle edge at the end keeps psel from being set twice in one step
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      erq = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string name);
      apb(a, 1'b0, 32'h0);
      chk(name, rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Watchdog, far beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge pclk);
      err_count++;
      summarize();
   end

   // Main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, conv_en, conv_pr, gie, irq_ack} = '0;
      paddr = 12'h0;
      pwdata = 32'h0;
      pos_mv = 100;
      neg_mv = 200;
      bg_mv = 300;
      ch_mv = '{default: 400};
      err_count = 0;
      n_checks = 0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(`CCL_ADDR_CSR, 32'h0, "csr reset");
      for (int a = 'h34; a <= 'h40; a += 4)
         rdchk(12'(a), 32'h0, "reg reset");
      apb(12'hFFC, 1'b0, 32'h0);
      chk("unmapped err", erq, 32'h1);
      chk("unmapped data", rd, 32'h0);
      wr_csr_ro: apb(`CCL_ADDR_CSR, 1'b1, 32'h20);
      rdchk(`CCL_ADDR_CSR, 32'h0, "result write");
      // Every mode code, rising then falling; enable stays off while the mode changes
      for (int m = 0; m < 4; m++) begin
         apb(`CCL_ADDR_CSR, 1'b1, 32'h10 | 32'(m));
         pos_mv <= 300;
         cyc(6);
         rdchk(`CCL_ADDR_CSR, 32'h20 | 32'(m) | ((m == 0 || m == 3) ? 32'h10 : 32'h0), "rise");
         apb(`CCL_ADDR_CSR, 1'b1, 32'h10 | 32'(m));
         pos_mv <= 100;
         cyc(6);
         rdchk(`CCL_ADDR_CSR, 32'(m) | ((m == 0 || m == 2) ? 32'h10 : 32'h0), "fall");
      end
      // Interrupt request, global enable, local enable, mask and both clears
      apb(`CCL_ADDR_CSR, 1'b1, 32'h13);
      apb(`CCL_ADDR_IMSK, 1'b1, 32'h1);
      gie <= 1'b1;
      apb(`CCL_ADDR_CSR, 1'b1, 32'h0B);
      pos_mv <= 300;
      cyc(6);
      chk("irq on", irq, 32'h1);
      gie <= 1'b0;
      cyc(2);
      chk("irq gie off", irq, 32'h0);
      gie <= 1'b1;
      apb(`CCL_ADDR_CSR, 1'b1, 32'h03);
      cyc(2);
      chk("irq ien off", irq, 32'h0);
      apb(`CCL_ADDR_CSR, 1'b1, 32'h0B);
      cyc(2);
      chk("flag kept", irq, 32'h1);
      irq_ack <= 1'b1;
      cyc(1);
      irq_ack <= 1'b0;
      cyc(2);
      chk("irq after ack", irq, 32'h0);
      rdchk(`CCL_ADDR_IST, 32'h0, "ist after ack");
      pos_mv <= 100;
      cyc(4);
      pos_mv <= 300;
      cyc(6);
      rdchk(`CCL_ADDR_IST, 32'h1, "ist set");
      apb(`CCL_ADDR_IST, 1'b1, 32'h1);
      rdchk(`CCL_ADDR_IST, 32'h0, "ist w1c");
      chk("irq cleared", irq, 32'h0);
      // Capture route, enable off from here on
      apb(`CCL_ADDR_CSR, 1'b1, 32'h04);
      cyc(3);
      chk("capture high", capture_out, 32'h1);
      pos_mv <= 100;
      cyc(6);
      chk("capture low", capture_out, 32'h0);
      // Bandgap in place of the positive pin, then power off
      apb(`CCL_ADDR_CSR, 1'b1, 32'h50);
      chk("bandgap pin", bg_sel, 32'h1);
      cyc(6);
      rdchk(`CCL_ADDR_CSR, 32'h70, "bandgap result");
      apb(`CCL_ADDR_CSR, 1'b1, 32'h90);
      chk("power off pin", pwr_off, 32'h1);
      cyc(6);
      rdchk(`CCL_ADDR_CSR, 32'h90, "power off toggle");
      // Converter channels as negative input; reserved mode keeps the flag quiet
      apb(`CCL_ADDR_CSR, 1'b1, 32'h11);
      pos_mv <= 300;
      apb(`CCL_ADDR_CCB, 1'b1, 32'h40);
      for (int c = 0; c < 8; c++) begin
         apb(`CCL_ADDR_MUX, 1'b1, 32'(c));
         ch_mv[c] <= 100;
         cyc(6);
         chk("use mux", use_mux, 32'h1);
         chk("channel", chan, 32'(c));
         rdchk(`CCL_ADDR_CSR, 32'h21, "channel result");
         ch_mv[c] <= 400;
      end
      conv_en <= 1'b1;
      cyc(2);
      chk("mux conv on", use_mux, 32'h0);
      conv_en <= 1'b0;
      conv_pr <= 1'b1;
      cyc(2);
      chk("mux power red", use_mux, 32'h0);
      summarize();
   end
endmodule
`default_nettype wire
